// ===== adcc_pkg.sv
// shared constants, register map and types of the converter control block
package adcc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RES_W   = 10;
  localparam int CH_W    = 4;
  localparam int DIV_W   = 3;
  localparam int TS_W    = 3;
  localparam int PIN_N   = 12;
  localparam int LO_PINS = 8;
  localparam int HI_PINS = 4;
  localparam int BB_W    = 3;
  localparam int IDX_W   = 4;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // conversion lengths in converter clock cycles
  // ----------------------------------------------------------------
  localparam int FIRST_CYCLES  = 25;
  localparam int NORMAL_CYCLES = 13;
  localparam int PRESC_W       = 7;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_DIDR_LO = 4'h1;
  localparam logic [IDX_W-1:0] IDX_CHSEL   = 4'h4;
  localparam logic [IDX_W-1:0] IDX_CTRL_A  = 4'h5;
  localparam logic [IDX_W-1:0] IDX_CTRL_B  = 4'h6;
  localparam logic [IDX_W-1:0] IDX_PORTCTL = 4'h8;
  localparam logic [IDX_W-1:0] IDX_RES_LO  = 4'hE;
  localparam logic [IDX_W-1:0] IDX_RES_HI  = 4'hF;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int REF_BIT   = 6;
  localparam int EN_BIT    = 7;
  localparam int START_BIT = 6;
  localparam int ATE_BIT   = 5;
  localparam int FLAG_BIT  = 4;
  localparam int IE_BIT    = 3;
  localparam int LEFT_BIT  = 3;
  localparam int HI_DIS_LSB = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [TS_W-1:0] TS_FREE = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {CONV_IDLE, CONV_RUN} adcc_conv_e;

  typedef struct packed {
    logic            power;
    logic            sample;
    logic            ref_internal;
    logic [CH_W-1:0] channel;
  } adcc_core_s;

  // bit 0 is comparator, matching trigger source code 1
  typedef struct packed {
    logic t1_capture;
    logic t1_overflow;
    logic t1_compare_b;
    logic t0_overflow;
    logic t0_compare_a;
    logic ext_int0;
    logic comparator;
  } adcc_trig_s;

endpackage

// ===== adcc_sync.sv
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
module adcc_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("adcc_sync: WIDTH must be at least 1");
    end
  endgenerate

  // only the second stage reads the first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ===== adcc_prescaler.sv
// converter clock prescaler, one tick per divided period
`timescale 1ns/1ps
module adcc_prescaler import adcc_pkg::*; #(
  parameter int CNT_W = PRESC_W
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  // control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div_sel,
  // divided clock as enable pulse
  output logic                  tick
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  generate
    if (CNT_W < PRESC_W) begin : g_chk
      $error("adcc_prescaler: CNT_W too small for divide by 128");
    end
  endgenerate

  // codes 0 and 1 both divide by two
  assign limit = (div_sel < 3'h2) ? CNT_W'(1) : CNT_W'((1 << div_sel) - 1);
  // a divider change can leave the count above the new limit; wrap at once, not after overflow
  assign tick  = run && (cnt >= limit);

  // held at zero while off so the first period is whole
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (clk_en) begin
      if (!run || tick) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

endmodule

// ===== adcc_top.sv
// converter control, triggering and result registers behind an ahb-lite slave
//
// Behaviour
// - channel field routes input, codes 0-15
// - channel change waits for running conversion
// - right alignment: high byte holds bits 9:8
// - left alignment: high byte holds bits 9:2
// - low byte read locks result until high
// - alignment change shows in result at once
// - enable powers on; clearing aborts conversion
// - start write begins conversion; free-run once
// - first conversion 25 cycles, later 13
// - start reads one while busy; zero ignored
// - auto trigger starts on rising source edge
// - done flag sets; clears by vector or one
// - interrupt needs flag, local and global enable
// - converter clock is system clock divided 2-128
// - trigger source field picks eight sources
// - switching to a set source makes edge
// - switching to free-run makes no trigger
// - low disable bits blank pins 0-7
// - port control 7:4 blank pins 8-11
// - reference select applies after running conversion
// - reference change makes next conversion 25 cycles
`timescale 1ns/1ps
module adcc_top import adcc_pkg::*; #(
  parameter int FIRST_LEN  = FIRST_CYCLES,
  parameter int NORMAL_LEN = NORMAL_CYCLES,
  parameter int CONV_CNT_W = 5
) (
  // clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic      [31:0]       hrdata,
  output logic                   hresp,
  // cpu interrupt side
  input  wire logic              global_irq_enable,
  input  wire logic              irq_ack,
  output logic                   conv_irq,
  // on-chip trigger sources
  input  wire adcc_trig_s        trig_flags,
  // analogue core
  output adcc_core_s             core_ctrl,
  input  wire logic [RES_W-1:0]  core_result,
  // pads
  input  wire logic [PIN_N-1:0]  pad_in,
  output logic      [PIN_N-1:0]  pad_in_disable,
  output logic      [PIN_N-1:0]  pin_read
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (NORMAL_LEN < 1 || FIRST_LEN < NORMAL_LEN || FIRST_LEN > (1 << CONV_CNT_W)) begin : g_chk
      $error("adcc_top: conversion lengths do not fit the counter");
    end
  endgenerate

  function automatic logic hit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] want);
    hit = (idx == want);
  endfunction

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic             wr_pend;
  logic             rd_wait;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic             addr_ok;
  logic [7:0]       wdat;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic               ref_sel;
  logic [CH_W-1:0]    channel_select_field;
  logic               converter_enable;
  logic               auto_trigger_enable;
  logic               conversion_done_flag;
  logic               conversion_irq_enable;
  logic [DIV_W-1:0]   clock_divider_select;
  logic               left_align_select;
  logic [TS_W-1:0]    trigger_source_select;
  logic [LO_PINS-1:0] pin_input_disable_lo;
  logic [HI_PINS-1:0] pin_input_disable_hi;
  logic [BB_W-1:0]    port_misc;
  logic [RES_W-1:0]   result;
  logic               result_lock;

  // ----------------------------------------------------------------
  // conversion state
  // ----------------------------------------------------------------
  adcc_conv_e          conv_state;
  logic [CONV_CNT_W-1:0] conv_cnt;
  logic                long_conv;
  logic                first_pend;
  logic                trig_prev;
  logic [CH_W-1:0]     act_channel;
  logic                act_ref;
  logic                sample_q;
  logic                power_q;
  logic                tick;
  logic [PIN_N-1:0]    pad_sync;

  // ----------------------------------------------------------------
  // address phase and write decode
  // ----------------------------------------------------------------
  // only whole-word accesses reach the registers; others still answer okay
  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign wdat    = hwdata[7:0];

  wire w_chsel   = wr_pend && hit(wr_idx, IDX_CHSEL);
  wire w_ctrla   = wr_pend && hit(wr_idx, IDX_CTRL_A);
  wire w_ctrlb   = wr_pend && hit(wr_idx, IDX_CTRL_B);
  wire w_didr    = wr_pend && hit(wr_idx, IDX_DIDR_LO);
  wire w_portctl = wr_pend && hit(wr_idx, IDX_PORTCTL);
  wire r_lo      = rd_wait && hit(rd_idx, IDX_RES_LO);
  wire r_hi      = rd_wait && hit(rd_idx, IDX_RES_HI);

  // reads take one wait state so hrdata comes from a flip-flop
  assign hreadyout = !rd_wait;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      wr_idx  <= '0;
      rd_idx  <= '0;
    end else if (clk_en) begin
      wr_pend <= addr_ok && hwrite;
      rd_wait <= addr_ok && !hwrite;
      if (addr_ok) begin
        wr_idx <= haddr[IDX_LSB +: IDX_W];
        rd_idx <= haddr[IDX_LSB +: IDX_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // start, trigger and abort
  // ----------------------------------------------------------------
  wire busy        = (conv_state == CONV_RUN);
  wire next_enable = w_ctrla ? wdat[EN_BIT] : converter_enable;
  wire kill        = w_ctrla && !wdat[EN_BIT];
  // writing zero to start does nothing; start while busy is absorbed
  wire start_req   = w_ctrla && wdat[START_BIT] && wdat[EN_BIT];

  wire [7:0] trig_vec = {trig_flags, conversion_done_flag};
  wire       trig_sel = trig_vec[trigger_source_select];
  wire       free_run = auto_trigger_enable && (trigger_source_select == TS_FREE);
  // source 0 is free-run, never an edge source even with the flag set
  wire trig_edge = auto_trigger_enable && !free_run && trig_sel && !trig_prev;

  wire [CONV_CNT_W-1:0] last_cnt = long_conv ? CONV_CNT_W'(FIRST_LEN - 1) : CONV_CNT_W'(NORMAL_LEN - 1);
  wire conv_done  = busy && tick && (conv_cnt == last_cnt) && !kill;
  wire conv_start = !kill && ((!busy && (start_req || (converter_enable && trig_edge)))
                              || (conv_done && free_run));
  wire ref_change = w_chsel && (wdat[REF_BIT] != ref_sel);

  // previous trigger level follows the selected source, so a switch can edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev <= 1'b0;
    end else if (clk_en) begin
      trig_prev <= trig_sel;
    end
  end

  // ----------------------------------------------------------------
  // converter clock
  // ----------------------------------------------------------------
  adcc_prescaler #(
    .CNT_W   (PRESC_W)
  ) u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .run     (converter_enable),
    .div_sel (clock_divider_select),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_state <= CONV_IDLE;
      conv_cnt   <= '0;
      long_conv  <= 1'b0;
    end else if (clk_en) begin
      case (conv_state)
        CONV_IDLE: begin
          if (conv_start) begin
            conv_state <= CONV_RUN;
            conv_cnt   <= '0;
            long_conv  <= first_pend;
          end
        end
        CONV_RUN: begin
          if (kill) begin
            conv_state <= CONV_IDLE;
          end else if (conv_start) begin
            conv_cnt  <= '0;
            long_conv <= first_pend;
          end else if (conv_done) begin
            conv_state <= CONV_IDLE;
          end else if (tick) begin
            conv_cnt <= conv_cnt + CONV_CNT_W'(1);
          end
        end
        default: begin
          conv_state <= CONV_IDLE;
        end
      endcase
    end
  end

  // first conversion after enable, or after a reference change, is long
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_pend <= 1'b1;
    end else if (clk_en) begin
      first_pend <= !next_enable || ref_change || (first_pend && !conv_start);
    end
  end

  // selections are frozen for the running conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_channel <= '0;
      act_ref     <= 1'b0;
    end else if (clk_en && (!busy || conv_done)) begin
      act_channel <= channel_select_field;
      act_ref     <= ref_sel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_q <= 1'b0;
      power_q  <= 1'b0;
    end else if (clk_en) begin
      sample_q <= conv_start;
      power_q  <= next_enable;
    end
  end

  assign core_ctrl.power        = power_q;
  assign core_ctrl.sample       = sample_q;
  assign core_ctrl.ref_internal = act_ref;
  assign core_ctrl.channel      = act_channel;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_sel              <= 1'b0;
      channel_select_field <= '0;
    end else if (clk_en && w_chsel) begin
      ref_sel              <= wdat[REF_BIT];
      channel_select_field <= wdat[CH_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_enable      <= 1'b0;
      auto_trigger_enable   <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_divider_select  <= '0;
    end else if (clk_en && w_ctrla) begin
      converter_enable      <= wdat[EN_BIT];
      auto_trigger_enable   <= wdat[ATE_BIT];
      conversion_irq_enable <= wdat[IE_BIT];
      clock_divider_select  <= wdat[DIV_W-1:0];
    end
  end

  // reserved and touch bits are not stored; they read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_align_select     <= 1'b0;
      trigger_source_select <= TS_FREE;
    end else if (clk_en && w_ctrlb) begin
      left_align_select     <= wdat[LEFT_BIT];
      trigger_source_select <= wdat[TS_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_input_disable_lo <= REG_RESET;
      pin_input_disable_hi <= '0;
      port_misc            <= '0;
    end else if (clk_en) begin
      if (w_didr) begin
        pin_input_disable_lo <= wdat;
      end
      if (w_portctl) begin
        pin_input_disable_hi <= wdat[HI_DIS_LSB +: HI_PINS];
        port_misc            <= wdat[BB_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // done flag and interrupt
  // ----------------------------------------------------------------
  wire flag_clr = irq_ack || (w_ctrla && wdat[FLAG_BIT]);

  // a completion in the clearing cycle wins, so no result goes unflagged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_done_flag <= 1'b0;
    end else if (clk_en) begin
      conversion_done_flag <= conv_done || (conversion_done_flag && !flag_clr);
    end
  end

  assign conv_irq = conversion_done_flag && conversion_irq_enable && global_irq_enable;

  // ----------------------------------------------------------------
  // result register and read lock
  // ----------------------------------------------------------------
  // a result finishing while locked is dropped, the locked pair is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= '0;
    end else if (clk_en && conv_done && !result_lock) begin
      result <= core_result;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_lock <= 1'b0;
    end else if (clk_en) begin
      if (r_lo) begin
        result_lock <= 1'b1;
      end else if (r_hi) begin
        result_lock <= 1'b0;
      end
    end
  end

  // view is combinational on the alignment bit, so it changes at once
  wire [7:0] result_low_byte  = left_align_select ? {result[1:0], 6'h00}
                                                  : result[7:0];
  wire [7:0] result_high_byte = left_align_select ? result[9:2]
                                                  : {6'h00, result[9:8]};

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [7:0] v_chsel = {1'b0, ref_sel, 2'h0, channel_select_field};
  wire [7:0] v_ctrla = {converter_enable, busy, auto_trigger_enable,
                        conversion_done_flag, conversion_irq_enable, clock_divider_select};
  wire [7:0] v_ctrlb = {4'h0, left_align_select, trigger_source_select};
  wire [7:0] v_port  = {pin_input_disable_hi, 1'b0, port_misc};

  wire [7:0] rd_view =
      hit(rd_idx, IDX_CHSEL)   ? v_chsel :
      hit(rd_idx, IDX_CTRL_A)  ? v_ctrla :
      hit(rd_idx, IDX_CTRL_B)  ? v_ctrlb :
      hit(rd_idx, IDX_DIDR_LO) ? pin_input_disable_lo :
      hit(rd_idx, IDX_PORTCTL) ? v_port :
      hit(rd_idx, IDX_RES_LO)  ? result_low_byte :
      hit(rd_idx, IDX_RES_HI)  ? result_high_byte : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (clk_en && rd_wait) begin
      hrdata <= {24'h000000, rd_view};
    end
  end

  // ----------------------------------------------------------------
  // digital pin inputs
  // ----------------------------------------------------------------
  adcc_sync #(
    .WIDTH    (PIN_N)
  ) u_pad_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  assign pad_in_disable = {pin_input_disable_hi, pin_input_disable_lo};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_read <= '0;
    end else if (clk_en) begin
      pin_read <= pad_sync & ~pad_in_disable;
    end
  end

endmodule

// ===== adcc_sva.sv
// port checks for the converter control block
`timescale 1ns/1ps
module adcc_sva import adcc_pkg::*; #(
  parameter int NORMAL_LEN = NORMAL_CYCLES
) (
  // clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // observed outputs and the global interrupt enable input
  input wire logic             hreadyout,
  input wire logic [31:0]      hrdata,
  input wire logic             global_irq_enable,
  input wire logic             conv_irq,
  input wire adcc_core_s       core_ctrl,
  input wire logic [PIN_N-1:0] pad_in_disable,
  input wire logic [PIN_N-1:0] pin_read
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles since the last sample; parked at top while off, since an abort may restart early
  logic [5:0] gap;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) gap <= 6'h3F;
    else if (core_ctrl.sample) gap <= 6'h00;
    else if (!core_ctrl.power) gap <= 6'h3F;
    else if (gap != 6'h3F) gap <= gap + 6'h01;
  AST_IRQ_GATE: assert property (conv_irq |-> global_irq_enable) else $error("irq unmasked");
  AST_PIN_LO: assert property ((pin_read[7:0] & $past(pad_in_disable[7:0])) == 8'h00) else $error("pin lo");
  AST_PIN_HI: assert property ((pin_read[11:8] & $past(pad_in_disable[11:8])) == 4'h0) else $error("pin hi");
  AST_SAMPLE_PWR: assert property (core_ctrl.sample |-> core_ctrl.power) else $error("sample while off");
  AST_SAMPLE_GAP: assert property (core_ctrl.sample |-> gap >= 2 * NORMAL_LEN - 2) else $error("too short");
  AST_CH_HOLD: assert property (core_ctrl.sample |=> ($stable(core_ctrl.channel) || !core_ctrl.power) [*8])
    else $error("channel moved");
  AST_REF_HOLD: assert property (core_ctrl.sample |=> ($stable(core_ctrl.ref_internal) || !core_ctrl.power) [*8])
    else $error("reference moved");
  AST_HI_ZERO: assert property (hreadyout |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
  cover property (core_ctrl.sample);
  cover property (conv_irq);
  cover property (pad_in_disable != 12'h000);
endmodule
bind adcc_top adcc_sva #(.NORMAL_LEN(NORMAL_LEN)) u_sva (.*);

// ===== adcc_core_model.sv
// behavioural analogue core: its code carries channel and reference
`timescale 1ns/1ps
module adcc_core_model import adcc_pkg::*; (
  // clock and control from the block
  input  wire logic             hclk,
  input  wire adcc_core_s       core_ctrl,
  // conversion code
  output logic      [RES_W-1:0] core_result
);
  // unpowered core is not held: inverse of the last code, so a stale read shows
  initial core_result = 10'h000;
  always @(posedge hclk)
    core_result <= core_ctrl.power ? {core_ctrl.channel, core_ctrl.ref_internal, 5'h0A} : ~core_result;
endmodule

// ===== tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top import adcc_pkg::*;;
  logic             hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, gie = 1'b1, irq_ack = 1'b0;
  logic             hreadyout, hresp, conv_irq;
  logic [1:0]       htrans = 2'h0;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [PIN_N-1:0] pad_in = 12'hFFF, pad_dis, pin_read;
  logic [RES_W-1:0] core_result;
  logic [7:0]       rd, ca;
  adcc_trig_s       trig = 7'h00;
  adcc_core_s       core_ctrl;
  int               n_mismatch, num_checks, cyc, tmo;
  int               divs [8] = '{2, 2, 4, 8, 16, 32, 64, 128};
  logic [3:0]       regs [7] = '{IDX_DIDR_LO, IDX_CHSEL, IDX_CTRL_A, IDX_CTRL_B, IDX_PORTCTL, IDX_RES_LO, IDX_RES_HI};
  adcc_top i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .global_irq_enable(gie), .irq_ack(irq_ack), .conv_irq(conv_irq), .trig_flags(trig),
    .core_ctrl(core_ctrl), .core_result(core_result), .pad_in(pad_in), .pad_in_disable(pad_dis), .pin_read(pin_read));
  adcc_core_model i_core (.hclk(hclk), .core_ctrl(core_ctrl), .core_result(core_result));
  initial forever #50 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= core_ctrl.sample ? 0 : cyc + 1;
    tmo <= tmo + 1;
    if (tmo == 30000) begin
      n_mismatch++;
      $display("mismatch t=%0t timeout", $time);
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {26'h0, idx, 2'h0};
    hwrite <= wr;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
    @(posedge hclk);
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk({4'h0, rd}, {4'h0, exp});
  endtask
  // length is judged from the sample pulse, in converter clocks of d system clocks
  task automatic wait_irq(input int n, input int d);
    do @(negedge hclk); while (conv_irq !== 1'b1);
    chk({11'h0, cyc >= (n - 1) * d - 1 && cyc <= n * d + 1}, 12'h001);
  endtask
  task automatic clr;
    bus(IDX_CTRL_A, 1'b1, ca | 8'h10);
    @(negedge hclk);
    chk({11'h0, conv_irq}, 12'h000);
  endtask
  initial begin
    ca = 8'h89;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    bus(4'h2, 1'b1, 8'hFF);
    rdchk(4'h2, 8'h00);
    $display("test reset done");
    bus(IDX_CHSEL, 1'b1, 8'h05);
    bus(IDX_CTRL_A, 1'b1, 8'hC9);
    wait_irq(25, 2);
    clr;
    rdchk(IDX_RES_LO, 8'h4A);
    rdchk(IDX_RES_HI, 8'h01);
    for (int c = 0; c < 8; c++) begin
      ca = 8'h88 | 8'(c);
      bus(IDX_CTRL_A, 1'b1, ca | 8'h40);
      wait_irq(13, divs[c]);
      clr;
    end
    bus(IDX_CTRL_A, 1'b1, 8'hCF);
    bus(IDX_CHSEL, 1'b1, 8'h09);
    rdchk(IDX_CTRL_A, 8'hCF);
    wait_irq(13, 128);
    clr;
    rdchk(IDX_RES_LO, 8'h4A);
    rdchk(IDX_RES_HI, 8'h01);
    $display("test timing done");
    ca = 8'h89;
    bus(IDX_CTRL_B, 1'b1, 8'h08);
    rdchk(IDX_RES_LO, 8'h80);
    rdchk(IDX_RES_HI, 8'h52);
    bus(IDX_CHSEL, 1'b1, 8'h49);
    repeat (10000) @(posedge hclk);
    rdchk(IDX_RES_LO, 8'h80);
    bus(IDX_CTRL_A, 1'b1, 8'hC9);
    wait_irq(25, 2);
    clr;
    rdchk(IDX_RES_HI, 8'h52);
    for (int c = 0; c < 16; c++) begin
      bus(IDX_CHSEL, 1'b1, 8'h40 | 8'(c));
      bus(IDX_CTRL_A, 1'b1, 8'hC9);
      wait_irq(13, 2);
      clr;
      rdchk(IDX_RES_HI, {4'(c), 4'hA});
    end
    bus(IDX_CTRL_A, 1'b1, 8'hC9);
    bus(IDX_CTRL_A, 1'b1, 8'h08);
    rdchk(IDX_CTRL_A, 8'h08);
    repeat (30) @(negedge hclk);
    chk({11'h0, conv_irq}, 12'h000);
    $display("test result and abort done");
    ca = 8'hA9;
    bus(IDX_CTRL_A, 1'b1, ca);
    for (int s = 1; s < 8; s++) begin
      bus(IDX_CTRL_B, 1'b1, 8'(s));
      trig <= adcc_trig_s'(7'h01 << (s - 1));
      wait_irq(s == 1 ? 25 : 13, 2);
      @(posedge hclk) trig <= 7'h00;
      clr;
    end
    bus(IDX_CTRL_B, 1'b1, 8'h01);
    trig <= 7'h08;
    bus(IDX_CTRL_B, 1'b1, 8'h04);
    wait_irq(13, 2);
    bus(IDX_CTRL_B, 1'b1, 8'h00);
    repeat (30) @(posedge hclk);
    gie <= 1'b0;
    @(negedge hclk);
    chk({11'h0, cyc > 40}, 12'h001);
    chk({11'h0, conv_irq}, 12'h000);
    @(posedge hclk) gie <= 1'b1;
    @(negedge hclk);
    chk({11'h0, conv_irq}, 12'h001);
    @(posedge hclk) irq_ack <= 1'b1;
    @(posedge hclk) irq_ack <= 1'b0;
    @(negedge hclk);
    chk({11'h0, conv_irq}, 12'h000);
    bus(IDX_CTRL_A, 1'b1, 8'hE9);
    wait_irq(13, 2);
    clr;
    wait_irq(13, 2);
    bus(IDX_CTRL_A, 1'b1, 8'h10);
    $display("test triggers done");
    bus(IDX_DIDR_LO, 1'b1, 8'h0F);
    bus(IDX_PORTCTL, 1'b1, 8'hFF);
    rdchk(IDX_PORTCTL, 8'hF7);
    rdchk(IDX_DIDR_LO, 8'h0F);
    @(negedge hclk);
    chk(pin_read, 12'h0F0);
    chk(pad_dis, 12'hF0F);
    chk({11'h0, hresp}, 12'h000);
    $display("test pins done");
    final_report;
  end
endmodule
